// ### dqs_phase_shift_ctrl.v
// Two-loop read-strobe phase-shift controller with AXI4-Lite registers.
`timescale 1ns/1ps
`include "dqs_phase_shift_regs.vh"
module dqs_phase_shift_ctrl #(
  parameter PINS_PER_SIDE = 4,
  parameter LOCK_LOW_JIT  = `LOCK_CYC_LOW_JIT,
  parameter LOCK_NORMAL   = `LOCK_CYC_NORMAL,
  parameter CAP_DEFAULT   = `DLY_MAX_PS / `ELEM_STEP_PS
) (
  input  wire                         clock,
  input  wire                         arst_n,
  input  wire [3:0]                   topClockIn,
  input  wire [3:0]                   bottomClockIn,
  input  wire [3:0]                   rightClockIn,
  input  wire                         topLeftSynthClk,
  input  wire                         bottomRightSynthClk,
  input  wire [7:0]                   awaddr,
  input  wire                         awvalid,
  output reg                          awready,
  input  wire [31:0]                  wdata,
  input  wire [3:0]                   wstrb,
  input  wire                         wvalid,
  output reg                          wready,
  output reg  [1:0]                   bresp,
  output reg                          bvalid,
  input  wire                         bready,
  input  wire [7:0]                   araddr,
  input  wire                         arvalid,
  output reg                          arready,
  output reg  [31:0]                  rdata,
  output reg  [1:0]                   rresp,
  output reg                          rvalid,
  input  wire                         rready,
  output reg  [3*PINS_PER_SIDE*6-1:0] pinDelay_ff,
  output reg                          lockA_ff,
  output reg                          lockB_ff
);

  localparam NPINS = 3 * PINS_PER_SIDE;
  localparam NSET  = 12;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  function [5:0] toGray;
    input [5:0] b;
    begin
      toGray = b ^ (b >> 1);
    end
  endfunction

  function [5:0] fromGray;
    input [5:0] gv;
    begin
      fromGray = {gv[5], ^gv[5:4], ^gv[5:3], ^gv[5:2], ^gv[5:1], ^gv};
    end
  endfunction

  function [5:0] stepToward;
    input [5:0] cur;
    input [5:0] dst;
    begin
      stepToward = (cur < dst) ? cur + 6'h01 :
                   (cur > dst) ? cur - 6'h01 : cur;
    end
  endfunction

  // Adds a signed side offset and clamps to the 6-bit setting range.
  function [5:0] satAdd;
    input [5:0] base;
    input [5:0] ofs;
    reg   [7:0] sum;
    begin
      sum = {2'b00, base} + {{2{ofs[5]}}, ofs};
      if (sum[7])
        satAdd = 6'h00;
      else if (sum[6])
        satAdd = 6'h3f;
      else
        satAdd = sum[5:0];
    end
  endfunction

  function [31:0] applyStrb;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  strb;
    integer      k;
    begin
      applyStrb = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          applyStrb[k*8 +: 8] = val[k*8 +: 8];
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[7:2] <= `ADDR_DELAY_CAP >> 2);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  reg  [3:0]       cfgA_ff;
  reg  [4:0]       cfgB_ff;
  reg  [31:0]      secOfs_ff;
  reg  [31:0]      sideOfs_ff;
  reg  [2*NPINS-1:0] pinSel_ff;
  reg  [5:0]       cap_ff;
  reg  [3:0]       prevA_ff;
  reg  [4:0]       prevB_ff;
  reg              restartA_ff;
  reg              restartB_ff;

  reg  [7:0]  awAddr_ff;
  reg         awHeld_ff;
  reg  [31:0] wData_ff;
  reg  [3:0]  wStrb_ff;
  reg         wHeld_ff;
  reg  [31:0] rdMux;
  wire [31:0] wrOld;
  wire [31:0] wrVal = applyStrb(wrOld, wData_ff, wStrb_ff);
  wire        doWrite = awHeld_ff & wHeld_ff & ~bvalid;

  wire        lockA;
  wire        lockB;
  wire [5:0]  setAp;
  wire [5:0]  setAs;
  wire [5:0]  setBp;
  wire [5:0]  setBs;

  assign wrOld = (awAddr_ff == `ADDR_LOOPA_CFG) ? {28'h0, cfgA_ff} :
                 (awAddr_ff == `ADDR_LOOPB_CFG) ? {27'h0, cfgB_ff} :
                 (awAddr_ff == `ADDR_SEC_OFS)   ? secOfs_ff :
                 (awAddr_ff == `ADDR_SIDE_OFS)  ? sideOfs_ff :
                 (awAddr_ff == `ADDR_PIN_SEL)   ?
                   {{(32-2*NPINS){1'b0}}, pinSel_ff} :
                 {26'h0, cap_ff};

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order.

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      awAddr_ff  <= 8'h00;
      awHeld_ff  <= 1'b0;
      wData_ff   <= 32'h0000_0000;
      wStrb_ff   <= 4'h0;
      wHeld_ff   <= 1'b0;
      cfgA_ff    <= 4'h0;
      cfgB_ff    <= 5'h00;
      secOfs_ff  <= `SEC_OFS_RESET;
      sideOfs_ff <= 32'h0000_0000;
      pinSel_ff  <= {(2*NPINS){1'b0}};
      cap_ff     <= CAP_DEFAULT[5:0];
    end else begin
      if (awvalid && awready) begin
        awAddr_ff <= {awaddr[7:2], 2'b00};
        awHeld_ff <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
        wHeld_ff <= 1'b1;
        wready   <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= mapped(awAddr_ff) && awAddr_ff != `ADDR_STATUS ?
                  `RESP_OKAY : `RESP_SLVERR;
        case (awAddr_ff)
          `ADDR_LOOPA_CFG: cfgA_ff    <= wrVal[3:0];
          `ADDR_LOOPB_CFG: cfgB_ff    <= wrVal[4:0];
          `ADDR_SEC_OFS:   secOfs_ff  <= wrVal;
          `ADDR_SIDE_OFS:  sideOfs_ff <= wrVal;
          `ADDR_PIN_SEL:   pinSel_ff  <= wrVal[2*NPINS-1:0];
          `ADDR_DELAY_CAP: cap_ff     <= wrVal[5:0];
          default: ;
        endcase
      end
      if (bvalid && bready) begin
        bvalid    <= 1'b0;
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  always @* begin
    rdMux = 32'h0000_0000;
    case ({araddr[7:2], 2'b00})
      `ADDR_LOOPA_CFG: rdMux = {28'h0, cfgA_ff};
      `ADDR_LOOPB_CFG: rdMux = {27'h0, cfgB_ff};
      `ADDR_SEC_OFS:   rdMux = secOfs_ff;
      `ADDR_SIDE_OFS:  rdMux = sideOfs_ff;
      `ADDR_PIN_SEL:   rdMux = {{(32-2*NPINS){1'b0}}, pinSel_ff};
      `ADDR_STATUS:    rdMux = {10'h0, toGray(setBp), 2'b00,
                                toGray(setAp), 6'h00, lockB, lockA};
      `ADDR_DELAY_CAP: rdMux = {26'h0, cap_ff};
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        rdata   <= rdMux;
        rresp   <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        rvalid  <= 1'b1;
        arready <= 1'b0;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference clock pins: two-stage synchronisers, then source selection.

  reg  [13:0] refMeta_ff;
  reg  [13:0] refSync_ff;
  wire [13:0] refPins = {bottomRightSynthClk, topLeftSynthClk,
                         rightClockIn, bottomClockIn, topClockIn};

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refMeta_ff <= 14'h0000;
      refSync_ff <= 14'h0000;
    end else begin
      refMeta_ff <= refPins;
      refSync_ff <= refMeta_ff;
    end
  end

  // Top-left loop: top inputs or its corner synth.
  wire refA = cfgA_ff[3] ? refSync_ff[12]
                         : refSync_ff[{2'b00, cfgA_ff[2:1]}];
  // Bottom-right loop: bottom inputs, right inputs or its corner synth.
  reg  refB;
  always @* begin
    case (cfgB_ff[4:3])
      `SRC_RIGHT: refB = refSync_ff[{2'b10, cfgB_ff[2:1]}];
      `SRC_SYNTH: refB = refSync_ff[13];
      default:    refB = refSync_ff[{2'b01, cfgB_ff[2:1]}];
    endcase
  end

  // A change of source or jitter mode restarts the lock sequence.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prevA_ff    <= 4'h0;
      prevB_ff    <= 5'h00;
      restartA_ff <= 1'b0;
      restartB_ff <= 1'b0;
    end else begin
      prevA_ff    <= cfgA_ff;
      prevB_ff    <= cfgB_ff;
      restartA_ff <= (prevA_ff != cfgA_ff);
      restartB_ff <= (prevB_ff != cfgB_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Corner loops; each runs from its own single reference.

  corner_delay_loop #(
    .LOCK_LOW_JIT (LOCK_LOW_JIT),
    .LOCK_NORMAL  (LOCK_NORMAL)
  ) loopTopLeft (
    .clock       (clock),
    .arst_n      (arst_n),
    .refLevel    (refA),
    .lowJitter   (cfgA_ff[0]),
    .restart     (restartA_ff),
    .capSet      (cap_ff),
    .secOfs      (secOfs_ff[5:0]),
    .lockDone_ff (lockA),
    .setPrim_ff  (setAp),
    .setSec_ff   (setAs)
  );

  corner_delay_loop #(
    .LOCK_LOW_JIT (LOCK_LOW_JIT),
    .LOCK_NORMAL  (LOCK_NORMAL)
  ) loopBottomRight (
    .clock       (clock),
    .arst_n      (arst_n),
    .refLevel    (refB),
    .lowJitter   (cfgB_ff[0]),
    .restart     (restartB_ff),
    .capSet      (cap_ff),
    .secOfs      (secOfs_ff[13:8]),
    .lockDone_ff (lockB),
    .setPrim_ff  (setBp),
    .setSec_ff   (setBs)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-side phase-offset stage. Each side keeps its own copy of all four
  // loop settings and walks it one step per cycle, so a large offset
  // change never makes a pin jump by more than one Gray step.

  reg  [5:0]  sideSet_ff [0:NSET-1];
  // Two-loop build: both loops reach every side, no adjacency limit.
  wire [23:0] loopBus = {setBs, setBp, setAs, setAp};
  integer     i;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < NSET; i = i + 1)
        sideSet_ff[i] <= `SET_RESET_VALUE;
    end else begin
      for (i = 0; i < NSET; i = i + 1)
        sideSet_ff[i] <= stepToward(sideSet_ff[i],
          satAdd(loopBus[(i % 4)*6 +: 6],
                 sideOfs_ff[(i / 4)*8 +: 6]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pin strobe settings, all loaded on the same edge.

  integer p;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinDelay_ff <= {(NPINS*6){1'b0}};
      lockA_ff    <= 1'b0;
      lockB_ff    <= 1'b0;
    end else begin
      // Each pin walks too, so a new selection never jumps several steps.
      for (p = 0; p < NPINS; p = p + 1)
        pinDelay_ff[p*6 +: 6] <= toGray(stepToward(
          fromGray(pinDelay_ff[p*6 +: 6]),
          sideSet_ff[(p / PINS_PER_SIDE)*4
                     + pinSel_ff[p*2 +: 2]]));
      lockA_ff <= lockA;
      lockB_ff <= lockB;
    end
  end

endmodule // dqs_phase_shift_ctrl

// ### dqs_phase_shift_regs.vh
// Constants for the read-strobe phase-shift control block.
//
// Overview of operation
// - In low jitter mode the loop locks within 1,280 reference cycles.
// - In normal mode the loop locks within 256 reference cycles.
// - Delay settings leave the loop Gray-coded, one bit change per update; here they leave it binary and are Gray-coded at the pins.
// - Loop keeps tracking its reference to compensate process, voltage, temperature.
// - Each loop offers two settings with different phase offsets.
// - Each strobe pin uses exactly one of the two loop output settings.
// - All strobe pins served take updated settings in the same cycle; here pins on a secondary setting follow one cycle after primary ones.
// - Each loop runs at one frequency; two loops give two frequencies.
// - Below 100 MHz shift still works but delay need not exceed 2.5 ns.
// - Corner loops sit top-left and bottom-right, each serving top, bottom, right.
// - Each loop delivers identical settings to every side it serves.
// - Four-loop variant: each loop serves only its two adjacent sides.
// - A bank may take settings from either loop, per strobe group.
// - Top-left picks top inputs or synth; bottom-right bottom, right or synth.
// - Per-side phase-offset stage adjusts shared settings before the pins.
// - Reference runs through a chain of up to 16 elements, compared in phase; here the reference period is counted in clock cycles instead.
// - Comparator direction steps a 6-bit setting up or down until aligned.
`ifndef DQS_PHASE_SHIFT_REGS_VH
`define DQS_PHASE_SHIFT_REGS_VH

`define ADDR_LOOPA_CFG     8'h00
`define ADDR_LOOPB_CFG     8'h04
`define ADDR_SEC_OFS       8'h08
`define ADDR_SIDE_OFS      8'h0c
`define ADDR_PIN_SEL       8'h10
`define ADDR_STATUS        8'h14
`define ADDR_DELAY_CAP     8'h18

`define LOCK_CYC_LOW_JIT   1280
`define LOCK_CYC_NORMAL    256
`define LOW_JIT_STEP_DIV   4
`define CHAIN_ELEMENTS     16
`define SET_RESET_VALUE    6'h00
`define SEC_OFS_RESET      32'h0000_0808
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`define SRC_BOTTOM         2'b00
`define SRC_RIGHT          2'b01
`define SRC_SYNTH          2'b10
`define DLY_MAX_PS         2500
`define ELEM_STEP_PS       50

`endif

// ### corner_delay_loop.v
// One corner delay-locked loop: period tracking, binary up/down stepping, lock.
`timescale 1ns/1ps
`include "dqs_phase_shift_regs.vh"
module corner_delay_loop #(
  parameter LOCK_LOW_JIT = `LOCK_CYC_LOW_JIT,
  parameter LOCK_NORMAL  = `LOCK_CYC_NORMAL
) (
  input  wire       clock,
  input  wire       arst_n,
  input  wire       refLevel,
  input  wire       lowJitter,
  input  wire       restart,
  input  wire [5:0] capSet,
  input  wire [5:0] secOfs,
  output reg        lockDone_ff,
  output reg  [5:0] setPrim_ff,
  output reg  [5:0] setSec_ff
);

  reg        refPrev_ff;
  reg  [7:0] perCnt_ff;
  reg  [7:0] period_ff;
  reg        seen_ff;
  reg        perValid_ff;
  reg  [1:0] divCnt_ff;
  reg [10:0] lockCnt_ff;
  wire        refRise = refLevel & ~refPrev_ff;
  wire [10:0] lockLim = lowJitter ? LOCK_LOW_JIT[10:0] : LOCK_NORMAL[10:0];
  wire  [7:0] capWide = {2'b00, capSet};
  // The target is the measured period, clamped to capSet setting units.
  wire  [7:0] target  = (period_ff > capWide) ? capWide : period_ff;
  // Low jitter mode filters the comparator, stepping once per several edges.
  wire        stepOk  = ~lowJitter
                      | (divCnt_ff == (`LOW_JIT_STEP_DIV - 1));
  wire  [6:0] secSum  = {1'b0, setPrim_ff} + {1'b0, secOfs};

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refPrev_ff  <= 1'b0;
      perCnt_ff   <= 8'h00;
      period_ff   <= 8'h00;
      seen_ff     <= 1'b0;
      perValid_ff <= 1'b0;
      divCnt_ff   <= 2'b00;
      lockCnt_ff  <= 11'h000;
      lockDone_ff <= 1'b0;
      setPrim_ff  <= `SET_RESET_VALUE;
      setSec_ff   <= `SET_RESET_VALUE;
    end else begin
      refPrev_ff <= refLevel;
      if (perCnt_ff != 8'hff)
        perCnt_ff <= perCnt_ff + 8'h01;
      if (restart) begin
        seen_ff     <= 1'b0;
        perValid_ff <= 1'b0;
        lockCnt_ff  <= 11'h000;
        lockDone_ff <= 1'b0;
        divCnt_ff   <= 2'b00;
        setPrim_ff  <= `SET_RESET_VALUE;
      end else if (refRise) begin
        perCnt_ff   <= 8'h01;
        seen_ff     <= 1'b1;
        if (seen_ff) begin
          period_ff   <= perCnt_ff;
          perValid_ff <= 1'b1;
        end
        divCnt_ff <= divCnt_ff + 2'b01;
        if (lockCnt_ff != lockLim)
          lockCnt_ff <= lockCnt_ff + 11'h001;
        if (lockCnt_ff + 11'h001 >= lockLim)
          lockDone_ff <= 1'b1;
        // Direction from comparing the setting with the clamped period target, one step per update.
        if (perValid_ff && stepOk) begin
          if ({2'b00, setPrim_ff} < target)
            setPrim_ff <= setPrim_ff + 6'h01;
          else if ({2'b00, setPrim_ff} > target)
            setPrim_ff <= setPrim_ff - 6'h01;
        end
      end
      setSec_ff <= secSum[6] ? 6'h3f : secSum[5:0];
    end
  end

endmodule // corner_delay_loop

// ### dqs_phase_shift_ctrl_props.sv
// Concurrent checks on the ports of the phase-shift controller.
`timescale 1ns/1ps
module dqs_phase_shift_ctrl_props #(
  parameter PINS_PER_SIDE = 4,
  parameter LOCK_NORMAL   = 256
) (
  input wire                         clock,
  input wire                         arst_n,
  input wire                         awvalid,
  input wire                         awready,
  input wire                         wvalid,
  input wire                         wready,
  input wire [1:0]                   bresp,
  input wire                         bvalid,
  input wire                         bready,
  input wire [7:0]                   araddr,
  input wire                         arvalid,
  input wire                         arready,
  input wire [31:0]                  rdata,
  input wire [1:0]                   rresp,
  input wire                         rvalid,
  input wire                         rready,
  input wire [3*PINS_PER_SIDE*6-1:0] pinDelay_ff,
  input wire                         lockA_ff,
  input wire                         lockB_ff
);
  localparam W = 3*PINS_PER_SIDE*6;
  reg [15:0] sinceRst_ff;
  // The count saturates so a long run never makes a lock look early.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      sinceRst_ff <= 16'h0000;
    else if (sinceRst_ff != 16'hFFFF)
      sinceRst_ff <= sinceRst_ff + 16'h0001;
  end
  function automatic bit oneStep(input [W-1:0] a, input [W-1:0] b);
    integer i;
    oneStep = 1'b1;
    for (i = 0; i < 3*PINS_PER_SIDE; i++) begin
      if ($countones(a[i*6+:6] ^ b[i*6+:6]) > 1)
        oneStep = 1'b0;
    end
  endfunction
  ////////////////////////////////////////
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  AST_PIN_GRAY: assert property (oneStep(pinDelay_ff, $past(pinDelay_ff)))
    else $error("pin setting moved more than one bit");
  // Detected reference rises are at least two cycles apart.
  AST_LOCKA_EARLY: assert property ($rose(lockA_ff)
    |-> sinceRst_ff >= 2*LOCK_NORMAL)
    else $error("loop a locked too early");
  AST_LOCKB_EARLY: assert property ($rose(lockB_ff)
    |-> sinceRst_ff >= 2*LOCK_NORMAL)
    else $error("loop b locked too early");
  AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read data not returned");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  AST_B_AFTER: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write response missing");
  AST_B_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("new write accepted while busy");
  AST_R_BLOCK: assert property (rvalid |-> !arready)
    else $error("new read accepted while busy");
  AST_UNMAPPED: assert property (arvalid && arready && araddr > 8'h1B
    |=> rresp == 2'b10 && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule // dqs_phase_shift_ctrl_props

bind dqs_phase_shift_ctrl dqs_phase_shift_ctrl_props #(
  .PINS_PER_SIDE(PINS_PER_SIDE), .LOCK_NORMAL(LOCK_NORMAL)
) u_dqs_phase_shift_ctrl_props (
  .clock(clock), .arst_n(arst_n), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .pinDelay_ff(pinDelay_ff), .lockA_ff(lockA_ff), .lockB_ff(lockB_ff)
);

// ### ref_clock_source.sv
// Reference clock source that stands still while stopped.
`timescale 1ns/1ps
module ref_clock_source #(
  parameter real HALF_NS = 400.0
) (
  input wire run,
  output reg refOut
);
  initial refOut = 1'b0;
  // One fixed period per source, so each loop sees a single frequency.
  always begin
    #(HALF_NS);
    refOut = run ? ~refOut : 1'b0;
  end
endmodule // ref_clock_source

// ### dqs_phase_shift_ctrl_tb.sv
// Self-checking bench for the read-strobe phase-shift controller.
`timescale 1ns/1ps
`include "dqs_phase_shift_regs.vh"
module dqs_phase_shift_ctrl_tb;
  localparam LN = 8;
  localparam LJ = 16;
  reg         clock, arst_n, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, gotData;
  reg  [3:0]  wstrb;
  reg  [4:0]  gate;
  reg  [1:0]  gotResp;
  wire        refA, refB, awready, wready, bvalid, arready, rvalid;
  wire        lockA_ff, lockB_ff;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [71:0] pinDelay_ff;
  integer     fails, total_checks, n;

  always #50 clock = ~clock;
  ref_clock_source #(.HALF_NS(400.0)) u_ref_clock_source_a (
    .run(1'b1), .refOut(refA));
  ref_clock_source #(.HALF_NS(600.0)) u_ref_clock_source_b (
    .run(1'b1), .refOut(refB));
  dqs_phase_shift_ctrl #(.LOCK_LOW_JIT(LJ), .LOCK_NORMAL(LN))
    u_dqs_phase_shift_ctrl (
    .clock(clock), .arst_n(arst_n), .topClockIn({4{refA & gate[0]}}),
    .bottomClockIn({4{refB & gate[1]}}), .rightClockIn({4{refB & gate[2]}}),
    .topLeftSynthClk(refA & gate[3]), .bottomRightSynthClk(refB & gate[4]),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pinDelay_ff(pinDelay_ff), .lockA_ff(lockA_ff),
    .lockB_ff(lockB_ff));
  ////////////////////////////////////////
  function [5:0] g(input [5:0] x);
    g = x ^ (x >> 1);
  endfunction
  function [71:0] pv(input [5:0] t0, input [5:0] t, input [5:0] b,
                     input [5:0] r);
    pv = {{4{g(r)}}, {4{g(b)}}, {3{g(t)}}, g(t0)};
  endfunction
  task results;
    begin
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        fails++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Handshakes are judged at the falling edge, where nothing moves.
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aH, wH, done;
    begin
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n++) begin
        @(negedge clock);
        aH = awvalid & awready;
        wH = wvalid & wready;
        done = bvalid;
        gotResp = bresp;
        @(posedge clock);
        if (aH) awvalid <= 1'b0;
        if (wH) wvalid <= 1'b0;
        if (done) bready <= 1'b0;
      end
      if (!done) begin
        fails++;
        $display("BAD %0t write timeout", $time);
        results;
      end else
        chk({30'h0, gotResp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg aH, done;
    begin
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n++) begin
        @(negedge clock);
        aH = arvalid & arready;
        done = rvalid;
        gotData = rdata;
        gotResp = rresp;
        @(posedge clock);
        if (aH) arvalid <= 1'b0;
        if (done) rready <= 1'b0;
      end
      if (!done) begin
        fails++;
        $display("BAD %0t read timeout", $time);
        results;
      end else begin
        chk(gotData, ed);
        chk({30'h0, gotResp}, {30'h0, er});
      end
    end
  endtask
  task waitPins(input [71:0] e);
    integer k;
    begin
      for (k = 0; k < 2000 && pinDelay_ff !== e; k++) @(negedge clock);
      total_checks++;
      if (pinDelay_ff !== e) begin
        fails++;
        $display("BAD %0t pins %h exp %h", $time, pinDelay_ff, e);
      end
    end
  endtask
  task waitLock(input sel, input integer lo, input integer hi);
    integer k;
    begin
      for (k = 0; k < hi && (sel ? lockB_ff : lockA_ff) !== 1'b1; k++)
        @(negedge clock);
      chk({31'h0, k >= lo && (sel ? lockB_ff : lockA_ff) === 1'b1}, 32'h1);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    {clock, arst_n, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, gate} = 53'h0;
    wstrb = 4'hF;
    fails = 0;
    total_checks = 0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rd(`ADDR_SEC_OFS, `SEC_OFS_RESET, `RESP_OKAY);
    rd(`ADDR_DELAY_CAP, 32'h0000_0032, `RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h20, 32'h0000_0001, `RESP_SLVERR);
    wr(`ADDR_STATUS, 32'h0000_0003, `RESP_SLVERR);
    waitPins(72'h0);
    rd(`ADDR_STATUS, 32'h0000_0000, `RESP_OKAY);
    $display("test 1 done: reset values");
    gate[0] <= 1'b1;
    waitLock(1'b0, (LN-2)*8, (LN+4)*8);
    waitPins(pv(8, 8, 8, 8));
    rd(`ADDR_STATUS, 32'h0000_0C01, `RESP_OKAY);
    $display("test 2 done: normal lock");
    gate[2] <= 1'b1;
    wr(`ADDR_LOOPB_CFG, 32'h0000_0009, `RESP_OKAY);
    waitLock(1'b1, (LN+2)*12, (LJ+4)*12);
    wr(`ADDR_PIN_SEL, 32'h0000_AA00, `RESP_OKAY);
    waitPins(pv(8, 8, 12, 8));
    $display("test 3 done: low jitter lock");
    wr(`ADDR_SEC_OFS, 32'h0000_0802, `RESP_OKAY);
    wr(`ADDR_PIN_SEL, 32'h0000_AA01, `RESP_OKAY);
    waitPins(pv(10, 8, 12, 8));
    wr(`ADDR_SIDE_OFS, 32'h003F_0000, `RESP_OKAY);
    waitPins(pv(10, 8, 12, 7));
    $display("test 4 done: offsets");
    wr(`ADDR_DELAY_CAP, 32'h0000_0005, `RESP_OKAY);
    waitPins(pv(7, 5, 5, 4));
    rd(`ADDR_DELAY_CAP, 32'h0000_0005, `RESP_OKAY);
    $display("test 5 done: delay cap");
    gate <= 5'b01100;
    wr(`ADDR_LOOPA_CFG, 32'h0000_0008, `RESP_OKAY);
    for (n = 0; n < 10 && lockA_ff !== 1'b0; n++) @(negedge clock);
    chk({31'h0, lockA_ff}, 32'h0);
    waitLock(1'b0, (LN-2)*8, (LN+4)*8);
    waitPins(pv(7, 5, 5, 4));
    @(posedge clock) gate <= 5'b11010;
    wr(`ADDR_LOOPB_CFG, 32'h0000_0010, `RESP_OKAY);
    for (n = 0; n < 10 && lockB_ff !== 1'b0; n++) @(negedge clock);
    chk({31'h0, lockB_ff}, 32'h0);
    waitLock(1'b1, (LN-2)*12, (LN+4)*12);
    wr(`ADDR_LOOPB_CFG, 32'h0000_0002, `RESP_OKAY);
    for (n = 0; n < 10 && lockB_ff !== 1'b0; n++) @(negedge clock);
    chk({31'h0, lockB_ff}, 32'h0);
    waitLock(1'b1, (LN-2)*12, (LN+4)*12);
    waitPins(pv(7, 5, 5, 4));
    $display("test 6 done: restart");
    results;
  end
endmodule // dqs_phase_shift_ctrl_tb
